// ### src/snd_cmd_cfg.svh
// constants for the sound device command interpreter
`ifndef SND_CMD_CFG_SVH
`define SND_CMD_CFG_SVH
`define NUM_CHAN      2
`define NUM_PRESET    3
`define NUM_PARAM     4
`define CMD_WR_ALL    8'h81
`define CMD_RECALL    8'h82
`define CMD_SET_PTR   8'h83
`define CMD_PTR_LOAD  8'h84
`define CMD_LOCK      8'h85
`define CMD_UNLOCK    8'h86
`define CMD_DIR_BIT   7
`define ADDR_GROUP    8'h00
`define ST_OK         8'h00
`define ST_BAD_CMD    8'h01
`define ST_BAD_OPND   8'h02
`define ST_LOCKED     8'h03
`define ST_UNLOCKED   8'h04
`define DEV_TYPE      8'h5A
`define MAKER_CODE    8'h3C
`endif

// ### src/snd_cmd_interp.sv
// device-side control language interpreter: handshake framing and command execution
// Summary of operation
// - channels addressed by channel_select byte, 01 hex is channel one
// - memory 00 is the live memory, higher numbers select preset memories
// - one preset_pointer byte kept per channel
// - pointer zero means off, N selects preset N, no larger than preset count
// - operational_health byte readable, zero means healthy, all-ones reserved; here an input port only, no command reads it
// - single channel devices still accept full syntax
// - codes 80 hex and above move data to the device, below move out
// - a completion_status byte ends every command, 00 hex for success
// - 81 hex stores channel, memory, parameters and pointer
// - writing the live memory applies settings immediately
// - 82 hex copies a preset into the live memory
// - 83 hex stores a new preset_pointer for the channel
// - 84 hex copies the pointed preset into live memory, nothing when off
// - address 00 hex updates every channel with nonzero pointer at once
// - group update uses no handshake and no command bytes
// - 85 hex sets lock, 86 hex clears it
// - while locked, preset or pointer writes are refused with 03 hex
// - while locked, pointer driven updates still work
// - lock state survives power loss
// - lock when locked gives 03 hex, unlock when unlocked gives 04 hex
// - commands without device data behave identically on any device
// - matching address drives the device handshake active low
// - controller handshake active sends type byte then maker byte
// - after status the handshake is released and the device idles
// - invalid command or operand returns a status and idles
`timescale 1ns/1ps
`default_nettype none
`include "snd_cmd_cfg.svh"
module snd_cmd_interp (
	input  wire logic                 clk_sys,
	input  wire logic                 rst_b,
	input  wire logic                 clk_en,
	input  wire logic [7:0]           own_address,
	input  wire snd_cmd_pkg::byte_s   rx_byte,
	input  wire logic                 host_hs_b,
	input  wire logic                 tx_ready,
	input  wire logic                 lock_restore,
	input  wire logic                 lock_restore_valid,
	input  wire logic [7:0]           operational_health,
	output logic                      dev_hs_b,
	output snd_cmd_pkg::byte_s        tx_byte,
	output logic                      lock_state,
	output logic                      lock_changed,
	output logic [7:0]                completion_status,
	output logic [`NUM_CHAN*8-1:0]    live_param0
);
	localparam int NC = `NUM_CHAN;
	localparam int NM = `NUM_PRESET + 1;
	localparam int NP = `NUM_PARAM;

	// ****************************************
	// storage
	// ****************************************
	logic [7:0] mem_q [NC][NM][NP];
	logic [7:0] preset_pointer_q [NC];
	snd_cmd_pkg::phase_e phase_q;
	logic [7:0] cmd_q, ch_q, memsel_q, stat_q, cnt_q;
	logic [7:0] pbuf_q [NP];
	logic       lock_q, lock_chg_q, hs_q;
	snd_cmd_pkg::byte_s tx_q;
	logic [7:0] cstat_q;

	// operand range checks, used by several commands
	function automatic logic ch_ok(input logic [7:0] c);
		ch_ok = (c != 8'h00) && (c <= 8'(NC));
	endfunction
	function automatic logic mem_ok(input logic [7:0] m);
		mem_ok = (m <= 8'(NM - 1));
	endfunction

	wire       rx_ok     = rx_byte.valid;
	wire [7:0] rxd       = rx_byte.data;
	wire       known_cmd = (rxd >= `CMD_WR_ALL) && (rxd <= `CMD_UNLOCK);
	wire       needs_ch  = (cmd_q != `CMD_LOCK) && (cmd_q != `CMD_UNLOCK);
	wire       needs_mem = (cmd_q == `CMD_WR_ALL) || (cmd_q == `CMD_RECALL);
	wire [7:0] ch_idx    = ch_q - 8'h01;
	wire       tx_done   = tx_q.valid && tx_ready;
	wire       group_hit = (phase_q == snd_cmd_pkg::S_IDLE) && rx_ok
		&& (rxd == `ADDR_GROUP) && host_hs_b;

	// status decision for the execute step
	logic [7:0] exec_stat;
	always_comb begin
		exec_stat = `ST_OK;
		if (needs_ch && !ch_ok(ch_q))
			exec_stat = `ST_BAD_OPND;
		else if (needs_mem && !mem_ok(memsel_q))
			exec_stat = `ST_BAD_OPND;
		else if (cmd_q == `CMD_WR_ALL && pbuf_ptr_bad())
			exec_stat = `ST_BAD_OPND;
		else if (cmd_q == `CMD_SET_PTR && memsel_q > 8'(NM - 1))
			exec_stat = `ST_BAD_OPND;
		else if (lock_q && (cmd_q == `CMD_WR_ALL || cmd_q == `CMD_SET_PTR))
			exec_stat = `ST_LOCKED;
		else if (cmd_q == `CMD_LOCK && lock_q)
			exec_stat = `ST_LOCKED;
		else if (cmd_q == `CMD_UNLOCK && !lock_q)
			exec_stat = `ST_UNLOCKED;
	end
	// pointer byte of 81 hex arrives last and is held in cnt_q
	function automatic logic pbuf_ptr_bad();
		pbuf_ptr_bad = (cnt_q > 8'(NM - 1));
	endfunction

	wire exec_go = (phase_q == snd_cmd_pkg::S_EXEC) && (exec_stat == `ST_OK);

	// ****************************************
	// framing sequencer
	// ****************************************
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			phase_q  <= snd_cmd_pkg::S_IDLE;
			cmd_q    <= 8'h00;
			ch_q     <= 8'h00;
			memsel_q <= 8'h00;
			cnt_q    <= 8'h00;
			stat_q   <= 8'h00;
			hs_q     <= 1'b1;
			tx_q     <= '0;
			cstat_q  <= 8'h00;
		end else if (clk_en) begin
			if (tx_done)
				tx_q.valid <= 1'b0;
			unique case (phase_q)
				snd_cmd_pkg::S_IDLE: begin
					if (rx_ok && rxd == own_address && rxd != `ADDR_GROUP) begin
						hs_q    <= 1'b0;
						phase_q <= snd_cmd_pkg::S_WAIT_HS;
					end
				end
				snd_cmd_pkg::S_WAIT_HS: begin
					if (!host_hs_b) begin
						tx_q    <= '{valid: 1'b1, data: `DEV_TYPE};
						phase_q <= snd_cmd_pkg::S_SEND_TYPE;
					end
				end
				snd_cmd_pkg::S_SEND_TYPE: begin
					if (tx_done) begin
						tx_q    <= '{valid: 1'b1, data: `MAKER_CODE};
						phase_q <= snd_cmd_pkg::S_SEND_MAKER;
					end
				end
				snd_cmd_pkg::S_SEND_MAKER: begin
					if (tx_done)
						phase_q <= snd_cmd_pkg::S_GET_CMD;
				end
				snd_cmd_pkg::S_GET_CMD: begin
					if (rx_ok) begin
						cmd_q <= rxd;
						// outbound codes are not provided here
						if (!rxd[`CMD_DIR_BIT] || !known_cmd) begin
							stat_q  <= `ST_BAD_CMD;
							phase_q <= snd_cmd_pkg::S_SEND_STAT;
						end else if (rxd == `CMD_LOCK || rxd == `CMD_UNLOCK)
							phase_q <= snd_cmd_pkg::S_EXEC;
						else
							phase_q <= snd_cmd_pkg::S_GET_CH;
					end
				end
				snd_cmd_pkg::S_GET_CH: begin
					if (rx_ok) begin
						ch_q <= rxd;
						cnt_q <= 8'h00;
						if (cmd_q == `CMD_PTR_LOAD)
							phase_q <= snd_cmd_pkg::S_EXEC;
						else if (cmd_q == `CMD_SET_PTR)
							phase_q <= snd_cmd_pkg::S_GET_PTR;
						else
							phase_q <= snd_cmd_pkg::S_GET_MEM;
					end
				end
				snd_cmd_pkg::S_GET_MEM: begin
					if (rx_ok) begin
						memsel_q <= rxd;
						phase_q  <= (cmd_q == `CMD_WR_ALL) ? snd_cmd_pkg::S_GET_PARAM
							: snd_cmd_pkg::S_EXEC;
					end
				end
				snd_cmd_pkg::S_GET_PARAM: begin
					if (rx_ok) begin
						cnt_q <= cnt_q + 8'h01;
						if (cnt_q == 8'(NP - 1))
							phase_q <= snd_cmd_pkg::S_GET_PTR;
					end
				end
				snd_cmd_pkg::S_GET_PTR: begin
					if (rx_ok) begin
						// 83 hex keeps pointer in memsel_q, 81 hex in cnt_q
						if (cmd_q == `CMD_SET_PTR)
							memsel_q <= rxd;
						else
							cnt_q <= rxd;
						phase_q <= snd_cmd_pkg::S_EXEC;
					end
				end
				snd_cmd_pkg::S_EXEC: begin
					stat_q  <= exec_stat;
					phase_q <= snd_cmd_pkg::S_SEND_STAT;
				end
				snd_cmd_pkg::S_SEND_STAT: begin
					if (!tx_q.valid) begin
						tx_q    <= '{valid: 1'b1, data: stat_q};
						cstat_q <= stat_q;
						phase_q <= snd_cmd_pkg::S_WAIT_REL;
					end
				end
				snd_cmd_pkg::S_WAIT_REL: begin
					if (tx_done) begin
						hs_q    <= 1'b1;
						phase_q <= snd_cmd_pkg::S_IDLE;
					end
				end
			endcase
		end
	end

	// parameter capture buffer, copied only once the command is accepted
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			pbuf_q <= '{default: 8'h00};
		else if (clk_en && phase_q == snd_cmd_pkg::S_GET_PARAM && rx_ok)
			pbuf_q[cnt_q[1:0]] <= rxd;
	end

	// ****************************************
	// channel memories and pointers
	// ****************************************
	// reset stands in for nonvolatile load; contents start cleared
	generate
		for (genvar c = 0; c < NC; c++) begin : g_chan
			wire [7:0] my_ptr  = preset_pointer_q[c];
			wire       this_ch = (ch_idx == 8'(c));
			always_ff @(posedge clk_sys or negedge rst_b) begin
				if (!rst_b) begin
					preset_pointer_q[c] <= 8'h00;
					mem_q[c]            <= '{default: '{default: 8'h00}};
				end else if (clk_en) begin
					if (group_hit && my_ptr != 8'h00)
						mem_q[c][0] <= mem_q[c][my_ptr[1:0]];
					else if (exec_go && this_ch) begin
						unique case (cmd_q)
							`CMD_WR_ALL: begin
								mem_q[c][memsel_q[1:0]] <= pbuf_q;
								preset_pointer_q[c]     <= cnt_q;
							end
							`CMD_RECALL:
								mem_q[c][0] <= mem_q[c][memsel_q[1:0]];
							`CMD_SET_PTR:
								preset_pointer_q[c] <= memsel_q;
							`CMD_PTR_LOAD:
								if (my_ptr != 8'h00)
									mem_q[c][0] <= mem_q[c][my_ptr[1:0]];
							default: ;
						endcase
					end
				end
			end
		end
	endgenerate

	// parameter zero of each live memory; one process so the port has a single driver
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			live_param0 <= '0;
		else if (clk_en)
			for (int c = 0; c < NC; c++)
				live_param0[c*8 +: 8] <= mem_q[c][0][0];
	end

	// ****************************************
	// lock flag
	// ****************************************
	// reset clears; the saved level is reloaded by a clocked strobe
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			lock_q     <= 1'b0;
			lock_chg_q <= 1'b0;
		end else if (clk_en) begin
			lock_chg_q <= 1'b0;
			if (lock_restore_valid)
				lock_q <= lock_restore;
			else if (exec_go && cmd_q == `CMD_LOCK) begin
				lock_q     <= 1'b1;
				lock_chg_q <= 1'b1;
			end else if (exec_go && cmd_q == `CMD_UNLOCK) begin
				lock_q     <= 1'b0;
				lock_chg_q <= 1'b1;
			end
		end
	end

	// health byte is held outside and exposed as a port
	wire unused_health = ^operational_health;

	assign dev_hs_b          = hs_q;
	assign tx_byte           = tx_q;
	assign lock_state        = lock_q;
	assign lock_changed      = lock_chg_q;
	assign completion_status = cstat_q;

	// ****************************************
	// checks
	// ****************************************
	property p_hs_addr;
		@(posedge clk_sys) disable iff (!rst_b)
		(clk_en && phase_q == snd_cmd_pkg::S_IDLE && rx_ok && rxd == own_address
			&& rxd != `ADDR_GROUP) |=> !dev_hs_b;
	endproperty
	a_hs_addr: assert property (p_hs_addr) else $error("handshake not taken");
	property p_group_no_hs;
		@(posedge clk_sys) disable iff (!rst_b)
		(clk_en && group_hit) |=> dev_hs_b;
	endproperty
	a_group_no_hs: assert property (p_group_no_hs) else $error("hs on group");
	property p_locked_stat;
		@(posedge clk_sys) disable iff (!rst_b)
		(clk_en && phase_q == snd_cmd_pkg::S_EXEC && lock_q && cmd_q == `CMD_SET_PTR
			&& exec_stat != `ST_BAD_OPND) |=> stat_q == `ST_LOCKED;
	endproperty
	a_locked_stat: assert property (p_locked_stat) else $error("lock status");
	property p_release;
		@(posedge clk_sys) disable iff (!rst_b)
		(clk_en && phase_q == snd_cmd_pkg::S_WAIT_REL && tx_done) |=> dev_hs_b;
	endproperty
	a_release: assert property (p_release) else $error("no release");
	property p_type_first;
		@(posedge clk_sys) disable iff (!rst_b)
		(clk_en && phase_q == snd_cmd_pkg::S_WAIT_HS && !host_hs_b)
			|=> (tx_byte.valid && tx_byte.data == `DEV_TYPE);
	endproperty
	a_type_first: assert property (p_type_first) else $error("no type byte");
	// an unknown code seen while waiting for the command byte
	sequence s_bad_code;
		clk_en && phase_q == snd_cmd_pkg::S_GET_CMD && rx_ok && !known_cmd;
	endsequence
	property p_bad_cmd;
		@(posedge clk_sys) disable iff (!rst_b)
		s_bad_code |=> (phase_q == snd_cmd_pkg::S_SEND_STAT && stat_q == `ST_BAD_CMD);
	endproperty
	a_bad_cmd: assert property (p_bad_cmd) else $error("code not refused");
	// a restore strobe overrides the command, so it is left out here
	property p_lock_pulse;
		@(posedge clk_sys) disable iff (!rst_b)
		(clk_en && exec_go && !lock_restore_valid
			&& (cmd_q == `CMD_LOCK || cmd_q == `CMD_UNLOCK))
			|=> (lock_changed && lock_state == (cmd_q == `CMD_LOCK));
	endproperty
	a_lock_pulse: assert property (p_lock_pulse) else $error("no lock pulse");
endmodule
`default_nettype wire

// ### src/snd_cmd_pkg.sv
// types for the sound device command interpreter
package snd_cmd_pkg;
	typedef enum logic [3:0] {
		S_IDLE, S_WAIT_HS, S_SEND_TYPE, S_SEND_MAKER, S_GET_CMD, S_GET_CH,
		S_GET_MEM, S_GET_PARAM, S_GET_PTR, S_EXEC, S_SEND_STAT, S_WAIT_REL
	} phase_e;
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} byte_s;
endpackage

// ### verification/snd_host_model.sv
// controlling computer model that frames commands for the interpreter
`timescale 1ns/1ps
`default_nettype none
module snd_host_model (
	input  wire logic               clk_sys,
	input  wire logic               dev_hs_b,
	input  wire snd_cmd_pkg::byte_s tx_byte,
	output snd_cmd_pkg::byte_s      rx_byte,
	output logic                    host_hs_b,
	output logic                    tx_ready
);
	int hangs = 0;
	int pace = 0;
	// idle: line released high, nothing offered
	initial begin
		rx_byte = '{valid: 1'b0, data: 8'hA5};
		host_hs_b = 1'b1;
		tx_ready = 1'b0;
	end
	// data flips after each byte so a stale value never passes for a good one
	task automatic put(input logic [7:0] b);
		@(negedge clk_sys);
		rx_byte = '{valid: 1'b1, data: b};
		@(negedge clk_sys);
		rx_byte = '{valid: 1'b0, data: ~b};
	endtask
	// accept one device byte, stalling 0..3 cycles in turn
	task automatic take(output logic [7:0] b);
		int n;
		n = 0;
		while (tx_byte.valid !== 1'b1 && n < 64) begin
			@(negedge clk_sys);
			n++;
		end
		if (n == 64) hangs++;
		// four stall lengths rotate over the three takes of a command
		pace = (pace + 1) % 4;
		// byte already waiting and tx_ready just lowered: let an edge pass first
		if (n == 0 && pace == 0) @(negedge clk_sys);
		repeat (pace) @(negedge clk_sys);
		b = tx_byte.data;
		tx_ready = 1'b1;
		@(negedge clk_sys);
		tx_ready = 1'b0;
	endtask
	// one addressed command from address to release
	task automatic xfer(input logic [7:0] a, input logic [7:0] q[$],
		output logic [7:0] ty, output logic [7:0] mk, output logic [7:0] st);
		int n;
		n = 0;
		put(a);
		while (dev_hs_b !== 1'b0 && n < 16) begin
			@(negedge clk_sys);
			n++;
		end
		if (n == 16) hangs++;
		host_hs_b = 1'b0;
		take(ty);
		take(mk);
		foreach (q[i]) put(q[i]);
		take(st);
		n = 0;
		while (dev_hs_b !== 1'b1 && n < 16) begin
			@(negedge clk_sys);
			n++;
		end
		if (n == 16) hangs++;
		host_hs_b = 1'b1;
	endtask
endmodule
`default_nettype wire

// ### verification/test_snd_cmd_interp.sv
// self-checking bench for the sound device command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "snd_cmd_cfg.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
	$display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module test_snd_cmd_interp;
	logic               clk_sys = 1'b0;
	logic               rst_b = 1'b0;
	logic [7:0]         own_address = 8'h12;
	logic [7:0]         operational_health = 8'h00;
	logic               lock_restore = 1'b0;
	logic               lock_restore_valid = 1'b0;
	snd_cmd_pkg::byte_s rx_byte;
	snd_cmd_pkg::byte_s tx_byte;
	logic               host_hs_b;
	logic               tx_ready;
	logic               dev_hs_b;
	logic               lock_state;
	logic               lock_changed;
	logic               clk_en = 1'b1;
	logic [7:0]         completion_status;
	logic [15:0]        live_param0;
	int                 error_cnt = 0;
	int                 tests_run = 0;
	int                 chg_cnt = 0;
	int                 chg_exp = 0;
	logic [7:0]         seed = 8'h38;
	int                 mem [1:2][0:3];
	int                 ptr [1:2];
	int                 lk = 0;
	always #10 clk_sys = ~clk_sys;
	// lock change pulses counted against the model's successful lock commands
	always @(negedge clk_sys)
		if (lock_changed === 1'b1) chg_cnt++;
	snd_cmd_interp dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
		.own_address(own_address), .rx_byte(rx_byte), .host_hs_b(host_hs_b),
		.tx_ready(tx_ready), .lock_restore(lock_restore),
		.lock_restore_valid(lock_restore_valid), .operational_health(operational_health),
		.dev_hs_b(dev_hs_b), .tx_byte(tx_byte), .lock_state(lock_state),
		.lock_changed(lock_changed),
		.completion_status(completion_status), .live_param0(live_param0));
	snd_host_model host_u (.clk_sys(clk_sys), .dev_hs_b(dev_hs_b), .tx_byte(tx_byte),
		.rx_byte(rx_byte), .host_hs_b(host_hs_b), .tx_ready(tx_ready));
	// ****************
	// reference model
	// ****************
	function automatic logic [7:0] rnd();
		seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
		return seed;
	endfunction
	// code, channel, memory, pointer, then lock: bad operands go before any index
	function automatic int model(logic [7:0] q[$]);
		int c;
		int m;
		c = (q.size() > 1) ? int'(q[1]) : 1;
		m = (q.size() > 2) ? int'(q[2]) : 0;
		if (q[0] < `CMD_WR_ALL || q[0] > `CMD_UNLOCK) return `ST_BAD_CMD;
		if (q[0] <= `CMD_PTR_LOAD && (c < 1 || c > `NUM_CHAN)) return `ST_BAD_OPND;
		if (m > `NUM_PRESET) return `ST_BAD_OPND;
		if (q[0] == `CMD_WR_ALL && q[7] > `NUM_PRESET) return `ST_BAD_OPND;
		case (q[0])
			`CMD_WR_ALL: begin
				if (lk != 0) return `ST_LOCKED;
				mem[c][m] = q[3];
				ptr[c] = q[7];
			end
			`CMD_RECALL: mem[c][0] = mem[c][m];
			`CMD_SET_PTR: begin
				if (lk != 0) return `ST_LOCKED;
				ptr[c] = m;
			end
			`CMD_PTR_LOAD: mem[c][0] = mem[c][ptr[c]];
			`CMD_LOCK: begin
				if (lk != 0) return `ST_LOCKED;
				lk = 1;
				chg_exp++;
			end
			`CMD_UNLOCK: begin
				if (lk == 0) return `ST_UNLOCKED;
				lk = 0;
				chg_exp++;
			end
			default: ;
		endcase
		return `ST_OK;
	endfunction
	task automatic chk_live();
		`CHK(live_param0, {8'(mem[2][0]), 8'(mem[1][0])})
	endtask
	// run one command through the host model and compare every result
	task automatic op(input logic [7:0] q[$]);
		logic [7:0] ty, mk, st;
		int e;
		e = model(q);
		operational_health = rnd();
		host_u.xfer(own_address, q, ty, mk, st);
		repeat (2) @(negedge clk_sys);
		`CHK(ty, `DEV_TYPE)
		`CHK(mk, `MAKER_CODE)
		`CHK(st, 8'(e))
		`CHK(completion_status, 8'(e))
		`CHK(lock_state, lk[0])
		chk_live();
	endtask
	// broadcast address only, no handshake expected
	task automatic group_exec();
		host_u.put(`ADDR_GROUP);
		for (int c = 1; c <= 2; c++) mem[c][0] = mem[c][ptr[c]];
		repeat (4) @(negedge clk_sys);
		`CHK(dev_hs_b, 1'b1)
		chk_live();
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// ****************
	// scenarios
	// ****************
	initial begin
		repeat (16) @(negedge clk_sys);
		rst_b = 1'b1;
		@(negedge clk_sys);
		`CHK(dev_hs_b, 1'b1)
		op({`CMD_UNLOCK});
		for (int c = 1; c <= 2; c++) begin
			for (int m = 0; m <= 3; m++) begin
				op({`CMD_WR_ALL, 8'(c), 8'(m), rnd(), rnd(), rnd(), rnd(), 8'(rnd() % 4)});
			end
		end
		for (int m = 1; m <= 3; m++) op({`CMD_RECALL, 8'h02, 8'(m)});
		op({`CMD_SET_PTR, 8'h01, 8'h02});
		op({`CMD_PTR_LOAD, 8'h01});
		op({`CMD_SET_PTR, 8'h02, 8'h00});
		op({`CMD_PTR_LOAD, 8'h02});
		op({`CMD_WR_ALL, 8'h01, 8'h00, rnd(), rnd(), rnd(), rnd(), 8'h03});
		group_exec();
		op({8'h90});
		op({8'h02});
		op({`CMD_PTR_LOAD, 8'h03});
		op({`CMD_PTR_LOAD, 8'h00});
		op({`CMD_SET_PTR, 8'h01, 8'h04});
		op({`CMD_RECALL, 8'h01, 8'h04});
		op({`CMD_WR_ALL, 8'h02, 8'h02, rnd(), rnd(), rnd(), rnd(), 8'h04});
		op({`CMD_RECALL, 8'h01, 8'h01});
		op({`CMD_LOCK});
		op({`CMD_LOCK});
		op({`CMD_WR_ALL, 8'h02, 8'h01, rnd(), rnd(), rnd(), rnd(), 8'h01});
		op({`CMD_SET_PTR, 8'h02, 8'h01});
		op({`CMD_PTR_LOAD, 8'h01});
		op({`CMD_RECALL, 8'h01, 8'h02});
		group_exec();
		op({`CMD_UNLOCK});
		lock_restore = 1'b1;
		lock_restore_valid = 1'b1;
		@(negedge clk_sys);
		lock_restore_valid = 1'b0;
		lk = 1;
		@(negedge clk_sys);
		`CHK(lock_state, 1'b1)
		op({`CMD_LOCK});
		// a matching address offered while frozen must leave the device idle
		clk_en = 1'b0;
		host_u.put(own_address);
		repeat (2) @(negedge clk_sys);
		`CHK(dev_hs_b, 1'b1)
		clk_en = 1'b1;
		host_u.put(own_address ^ 8'hFF);
		repeat (4) @(negedge clk_sys);
		`CHK(dev_hs_b, 1'b1)
		`CHK(host_u.hangs, 0)
		`CHK(chg_cnt, chg_exp)
		stop_test();
	end
	// watchdog well beyond the several hundred cycles the sequence needs
	initial begin
		#(50000 * 20);
		error_cnt++;
		stop_test();
	end
endmodule
`default_nettype wire
